// File: rtl/eeprom_pkg.sv
// What this block does
// - Write data is held in a 64-byte cache of 8 pages by 8 bytes.
// - After a Write command, bytes load until Stop; Stop starts programming.
// - Each loaded page costs one page time of at most 5 ms.
// - Past 64 bytes the load pointer wraps to cache page 0 byte 0.
// - While programming, every bus command is ignored without answer.
// - Aligned start writes the bytes to consecutive array addresses, across 4K blocks.
// - First cache page goes to the start page, later ones to following pages.
// - First data byte lands in cache page 0 at the address low bits.
// - Unaligned overflow rolls into the empty leading bytes of cache page 0.
// - Unaligned start programs cache page 0 first, then the rest in order.
// - Only loaded byte positions of a page are programmed.
// - Standby follows Stop and idle logic, and also any error ending.
// - Respond only when control byte select bits equal the strap pins.
// - Data line is only pulled low, never driven high.
// - Data changes only while the serial clock is low, except Start and Stop.
// - No acknowledge to own address while busy, so the master can poll.
// - Bytes aimed at protected blocks are dropped silently, the rest written.
package eeprom_pkg;
   // =====================================================================
   // Timing
   localparam int CLK_MHZ = 50;
   localparam int PAGE_TIME_US = 5000;
   localparam int PAGE_CYC = PAGE_TIME_US * CLK_MHZ;
   // =====================================================================
   // Cache geometry and addressing
   localparam int CACHE_BYTES = 64;
   localparam int PAGE_BYTES = 8;
   localparam int CACHE_PAGES = 8;
   localparam int ADDR_W = 13;
   localparam int FIFO_DEPTH = 8;
   localparam int BLOCK_LSB = 9;
   localparam logic [3:0] DEV_TYPE = 4'hA;
   // =====================================================================
   // Control and sequencing states
   typedef enum logic [1:0] {S_IDLE, S_RX, S_ACK, S_IGN} link_state_t;
   typedef enum logic [2:0] {P_LOAD, P_DRAIN, P_SCAN, P_BYTE, P_WR, P_WAIT} prog_phase_t;
endpackage : eeprom_pkg

// File: rtl/cache_if.sv
`timescale 1ns/1ns
// =====================================================================
// Cache memory port: one write, one registered read
interface cache_if;
   logic we;
   logic [5:0] waddr;
   logic [7:0] wdata;
   logic [5:0] raddr;
   logic [7:0] rdata;
   modport owner (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cache_if

// File: rtl/byte_fifo.sv
`timescale 1ns/1ns
// =====================================================================
// Small synchronous FIFO, valid and ready on both sides
module byte_fifo #(
   parameter int W = 8,
   parameter int DEPTH = eeprom_pkg::FIFO_DEPTH
) (
   input wire logic clock_i, // System clock
   input wire logic arst_n_i, // Async reset, low
   input wire logic in_valid_i, // Push request
   output logic in_ready_o, // Room for a word
   input wire logic [W-1:0] in_data_i, // Push data
   output logic out_valid_o, // Word available
   input wire logic out_ready_i, // Pop request
   output logic [W-1:0] out_data_o // Head word
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } fifo_state_t;
   fifo_state_t q, d;
   logic push;
   logic pop;

   // Honest full and empty straight from the count
   assign in_ready_o = q.cnt != (PW+1)'(DEPTH);
   assign out_valid_o = q.cnt != '0;
   assign out_data_o = q.mem[q.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Pointers wrap at the depth, which need not be a power of two
   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = in_data_i;
         d.wp = (q.wp == PW'(DEPTH-1)) ? '0 : PW'(q.wp + 1'b1);
      end
      if (pop)
         d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : PW'(q.rp + 1'b1);
      d.cnt = (PW+1)'(q.cnt + push - pop);
   end

   // State register
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         q <= '0;
      else
         q <= d;
   end
endmodule : byte_fifo

// File: rtl/cache_mem.sv
`timescale 1ns/1ns
// =====================================================================
// 64-byte page cache with registered read data
module cache_mem (
   input wire logic clock_i, // System clock
   input wire logic arst_n_i, // Async reset, low
   cache_if.store port // Write and read port
);
   typedef struct packed {
      logic [eeprom_pkg::CACHE_BYTES-1:0][7:0] mem;
      logic [7:0] rd;
   } mem_state_t;
   mem_state_t q, d;

   assign port.rdata = q.rd;

   // Read returns the old byte on a same-address write; the owner never overlaps them
   always_comb
   begin
      d = q;
      d.rd = q.mem[port.raddr];
      if (port.we)
         d.mem[port.waddr] = port.wdata;
   end

   // State register
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         q <= '0;
      else
         q <= d;
   end
endmodule : cache_mem

// File: rtl/eeprom_cache_write.sv
`timescale 1ns/1ns
// =====================================================================
// Two-wire write front end, page cache and array commit sequencer
module eeprom_cache_write #(
   parameter int PAGE_CYC = eeprom_pkg::PAGE_CYC
) (
   input wire logic clock_i, // 50 MHz system clock
   input wire logic arst_n_i, // Async reset, low
   input wire logic scl_i, // Serial clock pin level
   input wire logic sda_i, // Serial data pin level
   output logic sda_o, // Data pin drive value
   output logic sda_oe_n_o, // Low while pulling data low
   input wire logic [2:0] chip_select_straps_i, // Chip address pins
   input wire logic [3:0] prot_first_i, // First protected 4K block
   input wire logic [3:0] prot_count_i, // Number of protected blocks
   output logic array_we_o, // One-cycle array byte write
   output logic [12:0] array_addr_o, // Array byte address
   output logic [7:0] array_data_o, // Array byte data
   output logic busy_o, // Commit in progress
   output logic standby_o // Nothing pending
);
   localparam int TW = $clog2(PAGE_CYC);
   localparam logic [TW-1:0] TMR_LAST = TW'(PAGE_CYC - 1);

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic [2:0] cs_m;
      logic [2:0] cs_s;
      eeprom_pkg::link_state_t st;
      logic [2:0] bitcnt;
      logic [7:0] sh;
      logic [1:0] idx;
      logic drv;
      logic wr;
      logic [12:0] addr;
      logic [5:0] ptr;
      logic [63:0] loaded;
      eeprom_pkg::prog_phase_t ph;
      logic [2:0] pg;
      logic [2:0] by;
      logic [TW-1:0] tmr;
      logic oe_n;
      logic we;
      logic [12:0] waddr;
      logic [7:0] wdata;
   } state_t;
   state_t q, d;

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic byte_done;
   logic [7:0] rx_byte;
   logic busy;
   logic ctrl_ok;
   logic push_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic pop_ready;
   logic pop;
   logic [7:0] fifo_data;
   logic [12:0] tgt;
   logic [4:0] blk;
   logic prot_hit;
   logic go;
   cache_if cif ();

   // =====================================================================
   // Submodules
   byte_fifo #(.W(8), .DEPTH(eeprom_pkg::FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(push_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(rx_byte),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop_ready),
      .out_data_o(fifo_data)
   );

   cache_mem u_cache (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .port(cif.store)
   );

   // =====================================================================
   // Bus condition decode, all on synchronised copies
   assign scl_rise = q.scl_s & ~q.scl_p;
   assign scl_fall = ~q.scl_s & q.scl_p;
   assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
   assign rx_byte = {q.sh[6:0], q.sda_s};
   assign byte_done = (q.st == eeprom_pkg::S_RX) && scl_rise && (q.bitcnt == 3'h7);
   assign busy = q.ph != eeprom_pkg::P_LOAD;
   // Reads are not handled here, so only a write-type control byte matches
   assign ctrl_ok = (rx_byte[7:4] == eeprom_pkg::DEV_TYPE) && (rx_byte[3:1] == q.cs_s)
      && !rx_byte[0] && !busy;
   assign push_valid = byte_done && (q.idx == 2'h3) && !start_c && !stop_c;

   // Cache fill is held off while a commit reads the cache
   assign pop_ready = (q.ph == eeprom_pkg::P_LOAD) || (q.ph == eeprom_pkg::P_DRAIN);
   assign pop = fifo_out_valid & pop_ready;
   assign cif.we = pop;
   assign cif.waddr = q.ptr;
   assign cif.wdata = fifo_data;
   assign cif.raddr = {q.pg, q.by};

   // Cache page n goes to the start page plus n, byte offset kept
   assign tgt = {10'(q.addr[12:3] + 10'(q.pg)), q.by};
   assign blk = {1'b0, tgt[12:eeprom_pkg::BLOCK_LSB]};
   assign prot_hit = (blk >= {1'b0, prot_first_i})
      && (blk < 5'({1'b0, prot_first_i} + {1'b0, prot_count_i}));

   // =====================================================================
   // Next-state logic
   always_comb
   begin
      d = q;
      go = 1'b0;
      d.scl_m = scl_i;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_i;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.cs_m = chip_select_straps_i;
      d.cs_s = q.cs_m;
      d.we = 1'b0;
      // Link side: Start and Stop override any bit in flight
      if (start_c)
      begin
         d.st = eeprom_pkg::S_RX;
         d.bitcnt = 3'h0;
         d.idx = 2'h0;
         d.drv = 1'b0;
         d.oe_n = 1'b1;
      end
      else if (stop_c)
      begin
         d.st = eeprom_pkg::S_IDLE;
         d.oe_n = 1'b1;
         if (q.wr && !busy)
         begin
            d.ph = eeprom_pkg::P_DRAIN;
            d.wr = 1'b0;
         end
      end
      else
      begin
         unique case (q.st)
            eeprom_pkg::S_IDLE, eeprom_pkg::S_IGN:
               d.oe_n = 1'b1;
            eeprom_pkg::S_RX:
               if (scl_rise)
               begin
                  d.sh = rx_byte;
                  d.bitcnt = 3'(q.bitcnt + 1'b1);
                  if (q.bitcnt == 3'h7)
                  begin
                     unique case (q.idx)
                        2'h0:
                        begin
                           go = ctrl_ok;
                           if (ctrl_ok)
                           begin
                              d.loaded = '0;
                              d.wr = 1'b0;
                           end
                        end
                        2'h1:
                        begin
                           go = 1'b1;
                           d.addr[12:8] = rx_byte[4:0];
                        end
                        2'h2:
                        begin
                           go = 1'b1;
                           d.addr[7:0] = rx_byte;
                           d.ptr = {3'h0, rx_byte[2:0]};
                        end
                        default:
                        begin
                           // A full FIFO refuses the byte with a missing acknowledge
                           go = fifo_in_ready;
                           d.wr = q.wr | fifo_in_ready;
                        end
                     endcase
                     d.st = go ? eeprom_pkg::S_ACK : eeprom_pkg::S_IGN;
                     d.drv = 1'b0;
                     if (q.idx != 2'h3)
                        d.idx = 2'(q.idx + 1'b1);
                  end
               end
            eeprom_pkg::S_ACK:
               // Pull low on the first clock fall, release on the next
               if (scl_fall)
               begin
                  if (!q.drv)
                  begin
                     d.oe_n = 1'b0;
                     d.drv = 1'b1;
                  end
                  else
                  begin
                     d.oe_n = 1'b1;
                     d.st = eeprom_pkg::S_RX;
                     d.bitcnt = 3'h0;
                  end
               end
         endcase
      end
      // Cache fill, pointer wraps inside the 64 bytes
      if (pop)
      begin
         d.loaded[q.ptr] = 1'b1;
         d.ptr = 6'(q.ptr + 1'b1);
      end
      // Commit sequencer, one page time per loaded page
      unique case (q.ph)
         eeprom_pkg::P_LOAD:
            d.pg = 3'h0;
         eeprom_pkg::P_DRAIN:
            if (!fifo_out_valid)
               d.ph = eeprom_pkg::P_SCAN;
         eeprom_pkg::P_SCAN:
            if (|q.loaded[{q.pg, 3'h0} +: 8])
            begin
               d.ph = eeprom_pkg::P_BYTE;
               d.by = 3'h0;
               d.tmr = TW'(1);
            end
            else if (q.pg == 3'h7)
               d.ph = eeprom_pkg::P_LOAD;
            else
               d.pg = 3'(q.pg + 1'b1);
         eeprom_pkg::P_BYTE:
         begin
            d.ph = eeprom_pkg::P_WR;
            d.tmr = TW'(q.tmr + 1'b1);
         end
         eeprom_pkg::P_WR:
         begin
            d.tmr = TW'(q.tmr + 1'b1);
            if (q.loaded[{q.pg, q.by}] && !prot_hit)
            begin
               d.we = 1'b1;
               d.waddr = tgt;
               d.wdata = cif.rdata;
            end
            d.by = 3'(q.by + 1'b1);
            d.ph = (q.by == 3'h7) ? eeprom_pkg::P_WAIT : eeprom_pkg::P_BYTE;
         end
         eeprom_pkg::P_WAIT:
            if (q.tmr == TMR_LAST)
            begin
               d.ph = (q.pg == 3'h7) ? eeprom_pkg::P_LOAD : eeprom_pkg::P_SCAN;
               d.pg = 3'(q.pg + 1'b1);
            end
            else
               d.tmr = TW'(q.tmr + 1'b1);
         default:
            d.ph = eeprom_pkg::P_LOAD;
      endcase
   end

   // State register; the data line starts released
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q <= '0;
         q.oe_n <= 1'b1;
         {q.scl_m, q.scl_s, q.scl_p} <= 3'h7; // Idle bus is high, so no false edge at release
         {q.sda_m, q.sda_s, q.sda_p} <= 3'h7;
      end
      else
         q <= d;
   end

   // =====================================================================
   // Outputs
   assign sda_o = 1'b0;
   assign sda_oe_n_o = q.oe_n;
   assign array_we_o = q.we;
   assign array_addr_o = q.waddr;
   assign array_data_o = q.wdata;
   assign busy_o = busy;
   assign standby_o = ((q.st == eeprom_pkg::S_IDLE) || (q.st == eeprom_pkg::S_IGN))
      && !busy && !fifo_out_valid;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_ptr_wrap;
      pop && (q.ptr == 6'h3F) |=> (q.ptr == 6'h00) && q.loaded[63];
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("load pointer did not wrap");

   property p_quiet_busy;
      busy |-> sda_oe_n_o;
   endproperty
   a_quiet_busy: assert property (p_quiet_busy) else $error("drove data while busy");

   property p_stop_launch;
      stop_c && q.wr && !busy |=> q.ph == eeprom_pkg::P_DRAIN;
   endproperty
   a_stop_launch: assert property (p_stop_launch) else $error("stop did not start commit");

   property p_page_time;
      (q.ph == eeprom_pkg::P_WAIT) && (q.tmr == TMR_LAST) |=> q.ph != eeprom_pkg::P_WAIT;
   endproperty
   a_page_time: assert property (p_page_time) else $error("page time overran");

   property p_loaded_only;
      (q.ph == eeprom_pkg::P_WR) && !q.loaded[{q.pg, q.by}] |=> !array_we_o;
   endproperty
   a_loaded_only: assert property (p_loaded_only) else $error("wrote an unloaded byte");

   property p_offset;
      (q.ph == eeprom_pkg::P_WR) ##1 array_we_o |-> array_addr_o[2:0] == $past(q.by);
   endproperty
   a_offset: assert property (p_offset) else $error("byte offset mismatch");

   property p_strap;
      byte_done && (q.idx == 2'h0) && (rx_byte[3:1] != q.cs_s) && !start_c && !stop_c
         |=> (q.st == eeprom_pkg::S_IGN) ##1 sda_oe_n_o;
   endproperty
   a_strap: assert property (p_strap) else $error("answered a foreign select");

   property p_low_clock;
      $changed(sda_oe_n_o) && !$past(start_c) && !$past(stop_c) |-> !q.scl_s;
   endproperty
   a_low_clock: assert property (p_low_clock) else $error("data moved with clock high");

   property p_first_byte;
      byte_done && (q.idx == 2'h2) && !start_c && !stop_c |=> q.ptr == {3'h0, $past(rx_byte[2:0])};
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("start byte position wrong");

   property p_protect;
      (q.ph == eeprom_pkg::P_WR) && prot_hit |=> !array_we_o;
   endproperty
   a_protect: assert property (p_protect) else $error("wrote a protected byte");
endmodule : eeprom_cache_write

// File: tb/twi_master_model.sv
`timescale 1ns/1ns
// =====================================================================
// Two-wire bus master: owns the serial clock, only ever pulls data low
module twi_master_model (
   input wire logic clock_i, // System clock
   input wire logic sda_oe_n_i, // Device pulls data low when 0
   output logic scl_o, // Serial clock pin
   output logic sda_o // Resolved data wire
);
   logic pull_q;
   // Released wire floats high through the pull-up, never a stale value
   assign sda_o = !(pull_q || !sda_oe_n_i);
   // Clock stands high between frames
   initial
   begin
      scl_o = 1'b1;
      pull_q = 1'b0;
   end
   // One quarter of the 160 ns bit period, changes on falling edges only
   task automatic q;
      repeat (2) @(negedge clock_i);
   endtask : q
   // Start: data falls while the clock is high
   task automatic start;
      pull_q = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      pull_q = 1'b1;
      q();
      scl_o = 1'b0;
      q();
   endtask : start
   // Stop: data rises while the clock is high, clock then stays high
   task automatic stop;
      pull_q = 1'b1;
      q();
      scl_o = 1'b1;
      q();
      pull_q = 1'b0;
      q();
      q();
   endtask : stop
   // Eight bits MSB first, then sample the acknowledge well inside the high phase
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         pull_q = !b[i];
         q();
         scl_o = 1'b1;
         q();
         q();
         scl_o = 1'b0;
         q();
      end
      pull_q = 1'b0;
      q();
      scl_o = 1'b1;
      q();
      ack = !sda_o;
      q();
      scl_o = 1'b0;
      q();
   endtask : send
endmodule : twi_master_model

// File: tb/eeprom_cache_write_tb_top.sv
`timescale 1ns/1ns
// =====================================================================
// Bench: scoreboard of expected array writes built from the cache rules
module eeprom_cache_write_tb_top;
   localparam int PC = 64;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic scl;
   logic sda;
   logic sda_drv;
   logic sda_oe_n;
   logic [2:0] straps = 3'h5;
   logic [3:0] prot_first = 4'hF;
   logic [3:0] prot_count = 4'h0;
   logic we;
   logic [12:0] addr;
   logic [7:0] data;
   logic busy;
   logic standby;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int np;
   logic ack_m;
   logic [31:0] rng = 32'h61B8;
   logic [7:0] cache_d [64];
   bit loaded [64];
   int exp_q[$];

   always #10 clock = ~clock;

   eeprom_cache_write #(.PAGE_CYC(PC)) eeprom_cache_write_i (
      .clock_i(clock),
      .arst_n_i(arst_n),
      .scl_i(scl),
      .sda_i(sda),
      .sda_o(sda_drv),
      .sda_oe_n_o(sda_oe_n),
      .chip_select_straps_i(straps),
      .prot_first_i(prot_first),
      .prot_count_i(prot_count),
      .array_we_o(we),
      .array_addr_o(addr),
      .array_data_o(data),
      .busy_o(busy),
      .standby_o(standby)
   );
   twi_master_model twi_master_model_i (
      .clock_i(clock),
      .sda_oe_n_i(sda_oe_n),
      .scl_o(scl),
      .sda_o(sda)
   );

   // =====================================================================
   // Helpers
   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : next_rand
   function automatic bit prot(int t);
      int blk;
      blk = t / 512;
      return blk >= prot_first && blk < prot_first + prot_count;
   endfunction : prot
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // Each array write must be the next one the cache rules predict; sampled mid-cycle
   always @(negedge clock)
   begin
      if (arst_n && we === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(32'h1, 32'h0);
         else
            check({addr, data}, exp_q.pop_front());
      end
      if (arst_n && sda_oe_n === 1'b0)
         check(sda_drv, 1'b0);
   end
   // Hang guard, generous against at most about 32k cycles of traffic
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         bad_count++;
         test_done();
      end
   end

   // =====================================================================
   // One Write command; expectations are queued before Stop launches it
   task automatic wr(input int a, input int n, input logic [2:0] sel, output int np);
      logic ack;
      logic [7:0] b;
      int t;
      bit hit;
      np = 0;
      loaded = '{default: 1'b0};
      twi_master_model_i.start();
      twi_master_model_i.send({4'hA, sel, 1'b0}, ack);
      check(ack, sel === straps);
      if (ack)
      begin
         twi_master_model_i.send({3'h0, a[12:8]}, ack);
         twi_master_model_i.send(a[7:0], ack);
         for (int k = 0; k < n; k++)
         begin
            b = 8'(next_rand());
            t = (a % 8 + k) % 64;
            cache_d[t] = b;
            loaded[t] = 1'b1;
            twi_master_model_i.send(b, ack);
            check(ack, 1'b1);
         end
         for (int p = 0; p < 64; p++)
         begin
            t = ((a / 8 + p / 8) % 1024) * 8 + p % 8;
            if (loaded[p] && !prot(t))
               exp_q.push_back(t * 256 + cache_d[p]);
            if (p % 8 == 0)
               hit = 1'b0;
            if (loaded[p] && !hit)
            begin
               np++;
               hit = 1'b1;
            end
         end
      end
      twi_master_model_i.stop();
   endtask : wr
   // Commit phase: optional poll while busy, page timing only when not polled, then standby, then a second poll when polled
   task automatic settle(input int np, input bit poll);
      int len;
      logic ack;
      len = 0;
      while (busy !== 1'b1 && len < 40)
      begin
         @(negedge clock);
         len++;
      end
      check(busy, 1'b1);
      if (poll)
      begin
         twi_master_model_i.start();
         twi_master_model_i.send({4'hA, straps, 1'b0}, ack);
         twi_master_model_i.stop();
         check(ack, 1'b0);
      end
      len = 0;
      while (busy === 1'b1 && len < 2000)
      begin
         @(negedge clock);
         len++;
      end
      if (!poll)
         check(len >= np * PC - 8 && len <= np * PC + 40, 1'b1);
      check(exp_q.size(), 0);
      check(standby, 1'b1);
      if (poll)
      begin
         twi_master_model_i.start();
         twi_master_model_i.send({4'hA, straps, 1'b0}, ack);
         twi_master_model_i.stop();
         check(ack, 1'b1);
      end
   endtask : settle

   // =====================================================================
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clock);
      @(negedge clock);
      arst_n = 1'b1;
      check({busy, standby, sda_oe_n}, 3'h3);
      repeat (6) @(negedge clock);
      // Full aligned cache crossing a 4K block, polled while busy
      wr(32'h1F8, 64, straps, np);
      settle(np, 1'b1);
      // Unaligned start with two bytes past a full cache
      wr(32'h105, 66, straps, np);
      settle(np, 1'b0);
      // Short write wrapping the top of the array, stale flags must not leak
      wr(32'h1FFE, 3, straps, np);
      settle(np, 1'b0);
      // Second half lands in a protected block and is dropped
      prot_first = 4'h1;
      prot_count = 4'h1;
      wr(32'h1F8, 16, straps, np);
      settle(np, 1'b0);
      // Random starts and lengths, protection still active
      repeat (3)
      begin
         wr(int'(next_rand() % 8192), int'(next_rand() % 70) + 1, straps, np);
         settle(np, 1'b0);
      end
      // Every select code: only the strapped one answers
      straps = 3'(next_rand());
      repeat (6) @(negedge clock);
      for (int i = 0; i < 8; i++)
      begin
         wr(32'h40, 2, 3'(i), np);
         if (np > 0)
            settle(np, 1'b0);
         repeat (4) @(negedge clock);
         check(standby, 1'b1);
      end
      // Read-type and foreign device-type control bytes are refused
      twi_master_model_i.start();
      twi_master_model_i.send({4'hA, straps, 1'b1}, ack_m);
      twi_master_model_i.stop();
      check(ack_m, 1'b0);
      twi_master_model_i.start();
      twi_master_model_i.send({4'h5, straps, 1'b0}, ack_m);
      twi_master_model_i.stop();
      check(ack_m, 1'b0);
      check(standby, 1'b1);
      test_done();
   end
endmodule : eeprom_cache_write_tb_top
